// ===== logic/eil_pkg.sv
package eil_pkg;

  localparam logic [7:0] EIL_ADDR_MASK_TWO     = 8'hE7;
  localparam logic [7:0] EIL_ADDR_PRIORITY_TWO = 8'hF7;
  localparam logic [7:0] EIL_ADDR_PIN_CONFIG   = 8'hE4;
  localparam logic [7:0] EIL_ADDR_TIMER_CTRL   = 8'h88;
  localparam logic [7:0] EIL_PAGE_ZERO         = 8'h00;
  localparam logic [7:0] EIL_PAGE_CONFIG       = 8'h0F;

  localparam logic [7:0] EIL_MASK_TWO_RESET    = 8'h00;
  localparam logic [7:0] EIL_PRIORITY_TWO_RESET = 8'h00;
  localparam logic [7:0] EIL_PIN_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] EIL_EXT_BITS_MASK     = 8'h05;

  localparam int EIL_BIT_PORT_MATCH = 2;
  localparam int EIL_BIT_DROPOUT    = 0;
  localparam int EIL_BIT_A_TRIGGER  = 0;
  localparam int EIL_BIT_A_PENDING  = 1;
  localparam int EIL_BIT_B_TRIGGER  = 2;
  localparam int EIL_BIT_B_PENDING  = 3;
  localparam int EIL_BIT_A_POLARITY = 3;
  localparam int EIL_BIT_B_POLARITY = 7;
  localparam int EIL_LSB_A_SELECT   = 0;
  localparam int EIL_LSB_B_SELECT   = 4;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } eil_sfr_req_type;

  typedef struct packed {
    logic port_match;
    logic dropout;
  } eil_src_type;

  typedef struct packed {
    logic ext_a;
    logic ext_b;
  } eil_ack_type;

endpackage

// ===== logic/eil_ext_channel.sv
`timescale 1ns/1ns
module eil_ext_channel (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_port_pins,
  input  wire logic [2:0] i_pin_select,
  input  wire logic       i_polarity,
  input  wire logic       i_trigger_type,
  input  wire logic       i_vector_ack,
  input  wire logic       i_sw_wr,
  input  wire logic       i_sw_value,
  output logic            o_pending
);

  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic       level_reg;
  logic       active_prev_reg;
  logic       active;
  logic       rise;

  // Every pin is watched regardless of the crossbar; nothing is driven back.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= 8'hFF;
      sync2_reg <= 8'hFF;
      sync3_reg <= 8'hFF;
    end else begin
      sync1_reg <= i_port_pins; // [RULE_09]
      sync2_reg <= sync1_reg; // [RULE_18]
      sync3_reg <= sync2_reg;
    end
  end

  // The level follows a pin only once the second and third stages agree.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      level_reg <= 1'b1;
    end else if (sync2_reg[i_pin_select] == sync3_reg[i_pin_select]) begin
      level_reg <= sync3_reg[i_pin_select]; // [RULE_16]
    end
  end

  assign active = ~(level_reg ^ i_polarity); // [RULE_08]
  assign rise   = active & ~active_prev_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      active_prev_reg <= 1'b0;
    end else begin
      active_prev_reg <= active;
    end
  end

  // In edge mode a new edge wins over a clear in the same cycle.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pending <= 1'b0;
    end else if (!i_trigger_type) begin
      o_pending <= active; // [RULE_12]
    end else if (rise) begin
      o_pending <= 1'b1; // [RULE_18]
    end else if (i_vector_ack) begin
      o_pending <= 1'b0; // [RULE_11]
    end else if (i_sw_wr) begin
      o_pending <= i_sw_value;
    end
  end

endmodule

// ===== logic/eil_top.sv
`timescale 1ns/1ns
// Function
// [RULE_01] Unused mask and priority bits read zero
// [RULE_02] Mask bit two gates port-match requests
// [RULE_03] Mask bit zero gates dropout requests
// [RULE_04] Priority bit two sets port-match level
// [RULE_05] Priority bit zero sets dropout level
// [RULE_06] Mask register at E7 on every page
// [RULE_07] Priority register at F7, pages 00/0F
// [RULE_08] Trigger bit edge/level, polarity bit high/low
// [RULE_09] Pins sampled without disturbing crossbar use
// [RULE_10] Pending flags at timer control bits 1,3
// [RULE_11] Edge mode pending clears on vectoring
// [RULE_12] Level mode pending follows active input
// [RULE_13] Source holds input until request recognized
// [RULE_14] Source releases input before routine ends
// [RULE_15] Skip crossbar pin to dedicate it
// [RULE_16] Three-bit select picks port 1 pin
// [RULE_17] Polarity bits at pin config 7 and 3
// [RULE_18] Pins synchronized; edge sets pending flag
module eil_top (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rstn,
  input  wire eil_pkg::eil_sfr_req_type i_sfr_req,
  output logic [7:0]                    o_sfr_rdata,
  output logic                          o_sfr_hit,
  input  wire logic [7:0]               i_port1_pins,
  input  wire eil_pkg::eil_src_type     i_src_flags,
  input  wire eil_pkg::eil_ack_type     i_vector_ack,
  output eil_pkg::eil_src_type          o_src_req,
  output eil_pkg::eil_src_type          o_src_high_prio,
  output eil_pkg::eil_ack_type          o_ext_req,
  output logic [3:0]                    o_timer_ctrl_low
);
  import eil_pkg::*;

  logic [7:0] mask_two_reg;
  logic [7:0] priority_two_reg;
  logic [7:0] pin_config_reg;
  logic [1:0] trigger_reg;
  logic       pend_a;
  logic       pend_b;
  logic       sel_mask;
  logic       sel_prio;
  logic       sel_pin;
  logic       sel_timer_control_reg;
  logic [7:0] rdata_next;

  assign sel_mask = (i_sfr_req.addr == EIL_ADDR_MASK_TWO); // [RULE_06]
  assign sel_prio = (i_sfr_req.addr == EIL_ADDR_PRIORITY_TWO) &&
                    ((i_sfr_req.page == EIL_PAGE_ZERO) ||
                     (i_sfr_req.page == EIL_PAGE_CONFIG)); // [RULE_07]
  assign sel_pin  = (i_sfr_req.addr == EIL_ADDR_PIN_CONFIG) &&
                    (i_sfr_req.page == EIL_PAGE_CONFIG);
  assign sel_timer_control_reg = (i_sfr_req.addr == EIL_ADDR_TIMER_CTRL);

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_two_reg <= EIL_MASK_TWO_RESET;
    end else if (i_sfr_req.wr_en && sel_mask) begin
      mask_two_reg <= i_sfr_req.wdata & EIL_EXT_BITS_MASK; // [RULE_01]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      priority_two_reg <= EIL_PRIORITY_TWO_RESET;
    end else if (i_sfr_req.wr_en && sel_prio) begin
      priority_two_reg <= i_sfr_req.wdata & EIL_EXT_BITS_MASK; // [RULE_01]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_config_reg <= EIL_PIN_CONFIG_RESET;
    end else if (i_sfr_req.wr_en && sel_pin) begin
      pin_config_reg <= i_sfr_req.wdata; // [RULE_17]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      trigger_reg <= 2'h0;
    end else if (i_sfr_req.wr_en && sel_timer_control_reg) begin
      trigger_reg <= {i_sfr_req.wdata[EIL_BIT_B_TRIGGER], i_sfr_req.wdata[EIL_BIT_A_TRIGGER]};
    end
  end

  eil_ext_channel u_chan_a (
    .i_clk_sys      (i_clk_sys),
    .i_rstn         (i_rstn),
    .i_port_pins    (i_port1_pins),
    .i_pin_select   (pin_config_reg[EIL_LSB_A_SELECT +: 3]),
    .i_polarity     (pin_config_reg[EIL_BIT_A_POLARITY]),
    .i_trigger_type (trigger_reg[0]),
    .i_vector_ack   (i_vector_ack.ext_a),
    .i_sw_wr        (i_sfr_req.wr_en && sel_timer_control_reg),
    .i_sw_value     (i_sfr_req.wdata[EIL_BIT_A_PENDING]),
    .o_pending      (pend_a)
  );

  eil_ext_channel u_chan_b (
    .i_clk_sys      (i_clk_sys),
    .i_rstn         (i_rstn),
    .i_port_pins    (i_port1_pins),
    .i_pin_select   (pin_config_reg[EIL_LSB_B_SELECT +: 3]),
    .i_polarity     (pin_config_reg[EIL_BIT_B_POLARITY]),
    .i_trigger_type (trigger_reg[1]),
    .i_vector_ack   (i_vector_ack.ext_b),
    .i_sw_wr        (i_sfr_req.wr_en && sel_timer_control_reg),
    .i_sw_value     (i_sfr_req.wdata[EIL_BIT_B_PENDING]),
    .o_pending      (pend_b)
  );

  always_comb begin
    rdata_next = 8'h00;
    if (sel_mask) begin
      rdata_next = mask_two_reg;
    end else if (sel_prio) begin
      rdata_next = priority_two_reg;
    end else if (sel_pin) begin
      rdata_next = pin_config_reg;
    end else if (sel_timer_control_reg) begin
      rdata_next = {4'h0, pend_b, trigger_reg[1], pend_a, trigger_reg[0]}; // [RULE_10]
    end
  end

  // Read data appears one cycle after the read strobe.
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit   <= 1'b0;
    end else begin
      o_sfr_rdata <= i_sfr_req.rd_en ? rdata_next : 8'h00;
      o_sfr_hit   <= i_sfr_req.rd_en && (sel_mask || sel_prio || sel_pin || sel_timer_control_reg);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_src_req        <= '0;
      o_src_high_prio  <= '0;
      o_ext_req        <= '0;
      o_timer_ctrl_low <= 4'h0;
    end else begin
      o_src_req.port_match <= i_src_flags.port_match &
                              mask_two_reg[EIL_BIT_PORT_MATCH]; // [RULE_02]
      o_src_req.dropout    <= i_src_flags.dropout & mask_two_reg[EIL_BIT_DROPOUT]; // [RULE_03]
      o_src_high_prio.port_match <= priority_two_reg[EIL_BIT_PORT_MATCH]; // [RULE_04]
      o_src_high_prio.dropout    <= priority_two_reg[EIL_BIT_DROPOUT]; // [RULE_05]
      o_ext_req.ext_a  <= pend_a;
      o_ext_req.ext_b  <= pend_b;
      o_timer_ctrl_low <= {pend_b, trigger_reg[1], pend_a, trigger_reg[0]}; // [RULE_10]
    end
  end

endmodule

// ===== tb/eil_props.sv
`timescale 1ns/1ns
module eil_props (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rstn,
  input  wire eil_pkg::eil_sfr_req_type i_sfr_req,
  input  wire logic [7:0]               o_sfr_rdata,
  input  wire logic                     o_sfr_hit,
  input  wire logic [7:0]               i_port1_pins,
  input  wire eil_pkg::eil_src_type     i_src_flags,
  input  wire eil_pkg::eil_ack_type     i_vector_ack,
  input  wire eil_pkg::eil_src_type     o_src_req,
  input  wire eil_pkg::eil_ack_type     o_ext_req,
  input  wire logic [3:0]               o_timer_ctrl_low
);
  import eil_pkg::*;
  logic [1:0] mask_reg;
  logic [3:0] calm_reg;
  wire        rd = i_sfr_req.rd_en;
  wire        wr = i_sfr_req.wr_en;
  wire  [7:0] ad = i_sfr_req.addr;
  wire        pg = i_sfr_req.page == 8'h00 || i_sfr_req.page == 8'h0F;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) mask_reg <= 2'h0;
    else if (wr && ad == 8'hE7) mask_reg <= {i_sfr_req.wdata[2], i_sfr_req.wdata[0]};
  end
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) calm_reg <= 4'h0;
    else if (!$stable(i_port1_pins)) calm_reg <= 4'h0;
    else if (calm_reg != 4'hF) calm_reg <= calm_reg + 4'h1;
  end
  a_unused_bits_zero: assert property (
    rd && (ad == 8'hE7 || ad == 8'hF7) |=> (o_sfr_rdata & 8'hFA) == 8'h00)
    else $error("unused bits nonzero");
  a_mask_any_page: assert property (rd && ad == 8'hE7 |=> o_sfr_hit)
    else $error("mask register missed");
  a_prio_wrong_page: assert property (
    rd && ad == 8'hF7 && !pg |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
    else $error("priority seen on wrong page");
  a_prio_right_page: assert property (rd && ad == 8'hF7 && pg |=> o_sfr_hit)
    else $error("priority register missed");
  a_match_gate: assert property (
    o_src_req.port_match == $past(mask_reg[1] & i_src_flags.port_match))
    else $error("port match gating wrong");
  a_dropout_gate: assert property (
    o_src_req.dropout == $past(mask_reg[0] & i_src_flags.dropout))
    else $error("dropout gating wrong");
  a_pending_bit_map: assert property (
    o_timer_ctrl_low[1] == o_ext_req.ext_a && o_timer_ctrl_low[3] == o_ext_req.ext_b)
    else $error("pending bits misplaced");
  a_ack_clears_edge: assert property (
    i_vector_ack.ext_a && o_timer_ctrl_low[0] && calm_reg > 4'h7 && !wr ##1 !wr
    |=> ##1 !o_ext_req.ext_a) else $error("pending not cleared on vectoring");
endmodule
bind eil_top eil_props eil_props_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
  .i_sfr_req(i_sfr_req), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
  .i_port1_pins(i_port1_pins), .i_src_flags(i_src_flags), .i_vector_ack(i_vector_ack),
  .o_src_req(o_src_req), .o_ext_req(o_ext_req), .o_timer_ctrl_low(o_timer_ctrl_low));

// ===== tb/eil_src_model.sv
`timescale 1ns/1ns
module eil_src_model (
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_pol,
  input  wire logic       i_act,
  output logic [7:0]      o_pins = 8'hFF
);
  // Pins are dedicated to the source, no peripheral drives them.
  always @(posedge i_clk_sys) begin
    o_pins <= {8{~i_pol}};
    if (i_act) o_pins[i_sel] <= i_pol;
  end
endmodule

// ===== tb/eil_top_tb.sv
`timescale 1ns/1ns
module eil_top_tb;
  import eil_pkg::*;
  logic clk = 0, rstn = 0, act = 0, pol = 0, trig, hit;
  logic [2:0] sel = 0;
  logic [1:0] e;
  logic [7:0] pins, rdata, d;
  logic [3:0] tcl;
  eil_sfr_req_type req = '0;
  eil_src_type flags = '0, sreq, prio;
  eil_ack_type ack = '0, ereq;
  int n_mismatch = 0, samples_checked = 0;
  always #2 clk = ~clk;
  eil_top eil_top_i (.i_clk_sys(clk), .i_rstn(rstn), .i_sfr_req(req), .o_sfr_rdata(rdata),
    .o_sfr_hit(hit), .i_port1_pins(pins), .i_src_flags(flags), .i_vector_ack(ack),
    .o_src_req(sreq), .o_src_high_prio(prio), .o_ext_req(ereq), .o_timer_ctrl_low(tcl));
  eil_src_model eil_src_model_i (.i_clk_sys(clk), .i_sel(sel), .i_pol(pol), .i_act(act),
    .o_pins(pins));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] p, logic [7:0] v);
    @(posedge clk) req <= '{1'b1, 1'b0, a, p, v};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] p, logic [7:0] x, logic h);
    @(posedge clk) req <= '{1'b0, 1'b1, a, p, 8'h00};
    @(posedge clk) req <= '0;
    #1 check("rdata", rdata, x);
    check("hit", {7'h0, hit}, {7'h0, h});
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(21043));
    tick(16);
    rstn = 1;
    rd(8'hE7, 8'h05, 8'h00, 1);
    rd(8'hF7, 8'h00, 8'h00, 1);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(8'hE7, 8'($urandom), d);
      rd(8'hE7, 8'($urandom), d & 8'h05, 1);
      wr(8'hF7, 8'h0F, ~d);
      wr(8'hF7, 8'h05, d);
      rd(8'hF7, 8'h00, ~d & 8'h05, 1);
      rd(8'hF7, 8'h33, 8'h00, 0);
    end
    $display("test registers done");
    @(posedge clk) flags <= 2'b11;
    for (int i = 0; i < 2; i++) begin
      d = i ? 8'h01 : 8'h04;
      wr(8'hE7, 8'h00, d);
      wr(8'hF7, 8'h0F, d);
      tick(3);
      check("src_req", {6'h0, sreq}, {6'h0, d[2], d[0]});
      check("prio", {6'h0, prio}, {6'h0, d[2], d[0]});
    end
    $display("test gating done");
    for (int k = 0; k < 8; k++) begin
      {sel, pol, trig} = {(k < 2) ? 3'(7 * k) : 3'($urandom), k[0], k[1]};
      e = k[2] ? 2'b01 : 2'b10;
      tick(2);
      wr(8'hE4, 8'h0F, k[2] ? {pol, sel, pol, ~sel} : {pol, ~sel, pol, sel});
      tick(8);
      wr(8'h88, 8'h00, {5'h0, trig, 1'b0, trig});
      tick(3);
      check("idle", {6'h0, ereq}, 8'h00);
      act = 1;
      tick(8);
      check("active", {6'h0, ereq}, {6'h0, e});
      act = 0;
      tick(8);
      check("held", {6'h0, ereq}, {6'h0, trig ? e : 2'b00});
      @(posedge clk) ack <= e;
      @(posedge clk) ack <= '0;
      tick(4);
      check("vectored", {6'h0, ereq}, 8'h00);
    end
    $display("test pins done");
    tally_and_finish();
  end
endmodule
